// File: logic/asq_sequencer.v
// sweep-mode sequencer for the converter: control registers, channel walk, results, interrupt
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "asq_regs.vh"

// What this block does
// [RL1] single sweep converts each block input once
// [RL2] repeat sweep 0 loops forever, no interrupt
// [RL3] width picks 2/4/6/8 inputs from zero
// [RL4] software trigger starts sweep on start write
// [RL5] external trigger waits for falling pin edge
// [RL6] single sweep stops; software trigger clears start
// [RL7] writing start zero halts either sweep mode
// [RL8] single sweep completion raises interrupt request
// [RL9] each result lands in its channel register
// [RL10] group field swaps alternate input groups in
// [RL11] software keeps controls steady during conversion
// [RL12] software waits 1 us after reference connect
// [RL13] resolution bit picks 10 or 8 bits
// [RL14] refuse start without reference; refuse disconnect busy
// [RL15] channels visited ascending from zero upward
module asq_sequencer (
   input wire clk,
   input wire rst,
   input wire [7:0] bus_addr,
   input wire [31:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   output reg [31:0] bus_rdata,
   input wire external_trigger_pin,
   output reg conv_go,
   output reg [2:0] conv_channel,
   output wire [1:0] input_group_field,
   output wire conv_res10,
   output wire reference_connect_bit,
   input wire conv_done,
   input wire [9:0] conv_data,
   output wire busy,
   output wire irq
);

   // software view, one word per byte address:
   //   control 0: start, trigger select, repeat sweep mode 0
   //   control 1: sweep width, 10-bit results, reference connect
   //   control 2: input group
   //   status: sweep done, sticky, read only
   //   clear: write 1 to drop the done flag, reads zero
   //   enable: done interrupt enable
   //   results: one word per channel from the result base
   // limitation: a refused start is silent, software must read start back

   // control and status register copies, sweep state, trigger history and results
   reg start_r;
   reg trgsel_r;
   reg repeat_r;
   reg [1:0] width_r;
   reg res10_r;
   reg refcon_r;
   reg [1:0] group_r;
   reg status_r;
   reg enable_r;
   reg [1:0] state_r;
   reg [2:0] chan_r;
   reg trig_prev_r;
   reg [9:0] result_r [0:7];
   // next values of the registered state
   reg [1:0] state_nxt;
   reg start_nxt;
   reg [2:0] chan_nxt;
   reg go_nxt;
   reg [2:0] channel_nxt;
   reg status_nxt;
   reg [31:0] rdata_nxt;
   // per-channel result write enables
   wire [7:0] res_we;

   wire wr_c0 = bus_wr && (bus_addr == `ASQ_ADDR_CTRL0);
   wire wr_c1 = bus_wr && (bus_addr == `ASQ_ADDR_CTRL1);
   wire wr_c2 = bus_wr && (bus_addr == `ASQ_ADDR_CTRL2);
   wire wr_clr = bus_wr && (bus_addr == `ASQ_ADDR_CLEAR);
   wire wr_en = bus_wr && (bus_addr == `ASQ_ADDR_ENABLE);

   // start may only be set once the reference is already connected, so a
   // write that would connect and start together never starts anything
   wire start_set = wr_c0 && bus_wdata[`ASQ_C0_START] && !start_r && refcon_r; // [RL14]
   wire start_clear = wr_c0 && !bus_wdata[`ASQ_C0_START]; // [RL7]

   // last channel of the block is 2*width+1: 1, 3, 5 or 7
   wire [2:0] last_chan = {width_r, 1'b1}; // [RL3]
   wire sweep_end = (state_r == `ASQ_ST_CONV) && conv_done && (chan_r == last_chan);
   wire single_done = sweep_end && !repeat_r; // [RL8]
   wire trig_fall = trig_prev_r && !external_trigger_pin; // [RL5]

   assign busy = (state_r != `ASQ_ST_IDLE);
   assign input_group_field = group_r; // [RL10]
   assign conv_res10 = res10_r;
   assign reference_connect_bit = refcon_r;
   assign irq = status_r && enable_r;

   // trigger pin history for the falling-edge detector
   always @(posedge clk) begin
      if (rst) begin
         trig_prev_r <= 1'b1;
      end else begin
         trig_prev_r <= external_trigger_pin;
      end
   end

   // control 0 mode bits; software must leave them alone mid-run,
   // so they are used live rather than latched per sweep
   always @(posedge clk) begin
      if (rst) begin
         trgsel_r <= 1'b0;
         repeat_r <= 1'b0;
      end else if (wr_c0) begin
         trgsel_r <= bus_wdata[`ASQ_C0_TRGSEL]; // [RL5]
         repeat_r <= bus_wdata[`ASQ_C0_REPEAT]; // [RL2]
      end
   end

   // sweep width and resolution of control 1
   always @(posedge clk) begin
      if (rst) begin
         width_r <= `ASQ_RST_WIDTH;
         res10_r <= 1'b0;
      end else if (wr_c1) begin
         width_r <= bus_wdata[`ASQ_C1_WIDTH_HI:`ASQ_C1_WIDTH_LO]; // [RL3]
         res10_r <= bus_wdata[`ASQ_C1_RES10]; // [RL13]
      end
   end

   // reference connect: a disconnect is refused while armed or converting,
   // the rest of the same write still lands
   always @(posedge clk) begin
      if (rst) begin
         refcon_r <= 1'b0;
      end else if (wr_c1 && (bus_wdata[`ASQ_C1_REFCON] || !busy)) begin
         refcon_r <= bus_wdata[`ASQ_C1_REFCON]; // [RL14]
      end
   end

   // input group of control 2
   always @(posedge clk) begin
      if (rst) begin
         group_r <= `ASQ_RST_GROUP;
      end else if (wr_c2) begin
         group_r <= bus_wdata[`ASQ_C2_GROUP_HI:`ASQ_C2_GROUP_LO]; // [RL10]
      end
   end

   // done interrupt enable
   always @(posedge clk) begin
      if (rst) begin
         enable_r <= 1'b0;
      end else if (wr_en) begin
         enable_r <= bus_wdata[`ASQ_ST_DONE];
      end
   end

   // sticky completion flag: a new completion beats a same-cycle clear,
   // so software never loses a sweep it has not yet seen
   always @* begin
      status_nxt = status_r;
      if (single_done) begin
         status_nxt = 1'b1; // [RL8]
      end else if (wr_clr && bus_wdata[`ASQ_ST_DONE]) begin
         status_nxt = 1'b0;
      end
   end

   // status register
   always @(posedge clk) begin
      if (rst) begin
         status_r <= 1'b0;
      end else begin
         status_r <= status_nxt;
      end
   end

   // next state of the sweep; a software halt wins over a same-cycle completion
   always @* begin
      state_nxt = state_r;
      start_nxt = start_r;
      chan_nxt = chan_r;
      go_nxt = 1'b0;
      channel_nxt = conv_channel;
      if (start_clear) begin
         start_nxt = 1'b0; // [RL7]
         state_nxt = `ASQ_ST_IDLE;
      end else begin
         case (state_r)
            `ASQ_ST_IDLE: begin
               if (start_set) begin
                  start_nxt = 1'b1;
                  chan_nxt = `ASQ_RST_CHAN;
                  if (bus_wdata[`ASQ_C0_TRGSEL]) begin
                     state_nxt = `ASQ_ST_ARM; // [RL5]
                  end else begin
                     state_nxt = `ASQ_ST_CONV; // [RL4]
                     go_nxt = 1'b1;
                     channel_nxt = `ASQ_RST_CHAN; // [RL15]
                  end
               end
            end
            `ASQ_ST_ARM: begin
               // only an edge seen after start was set counts
               if (trig_fall) begin
                  state_nxt = `ASQ_ST_CONV; // [RL5]
                  chan_nxt = `ASQ_RST_CHAN;
                  go_nxt = 1'b1;
                  channel_nxt = `ASQ_RST_CHAN;
               end
            end
            `ASQ_ST_CONV: begin
               if (conv_done) begin
                  if (chan_r != last_chan) begin
                     chan_nxt = chan_r + `ASQ_CHAN_ONE; // [RL15]
                     go_nxt = 1'b1;
                     channel_nxt = chan_r + `ASQ_CHAN_ONE; // [RL1]
                  end else if (repeat_r) begin
                     chan_nxt = `ASQ_RST_CHAN; // [RL2]
                     go_nxt = 1'b1;
                     channel_nxt = `ASQ_RST_CHAN;
                  end else if (trgsel_r) begin
                     // external trigger keeps start set and re-arms
                     state_nxt = `ASQ_ST_ARM;
                  end else begin
                     state_nxt = `ASQ_ST_IDLE;
                     start_nxt = 1'b0; // [RL6]
                  end
               end
            end
            default: begin
               state_nxt = `ASQ_ST_IDLE;
            end
         endcase
      end
   end

   // sweep registers; conv_go is a one-cycle pulse, conv_channel holds
   always @(posedge clk) begin
      if (rst) begin
         state_r <= `ASQ_ST_IDLE;
         start_r <= 1'b0;
         chan_r <= `ASQ_RST_CHAN;
         conv_go <= 1'b0;
         conv_channel <= `ASQ_RST_CHAN;
      end else begin
         state_r <= state_nxt;
         start_r <= start_nxt;
         chan_r <= chan_nxt;
         conv_go <= go_nxt;
         conv_channel <= channel_nxt;
      end
   end

   // one result register per channel index; a result that arrives with a
   // halt is dropped, since the sweep it belongs to was cancelled
   genvar gi;
   generate
      for (gi = 0; gi < `ASQ_NUM_CHAN; gi = gi + 1) begin : g_res
         assign res_we[gi] = (state_r == `ASQ_ST_CONV) && conv_done && !start_clear && (chan_r == gi); // [RL9]
         always @(posedge clk) begin
            if (rst) begin
               result_r[gi] <= `ASQ_RST_RESULT;
            end else if (res_we[gi]) begin
               // 8-bit mode keeps only the low byte
               result_r[gi] <= res10_r ? conv_data : (conv_data & `ASQ_MASK_8BIT); // [RL9] [RL13]
            end
         end
      end
   endgenerate

   // read multiplexer; only a read strobe produces data, so the port reads
   // zero in every other cycle
   always @* begin
      rdata_nxt = `ASQ_RST_RDATA;
      if (bus_rd) begin
         if ((bus_addr & `ASQ_ADDR_RES_MASK) == `ASQ_ADDR_RES_BASE) begin
            rdata_nxt = {22'h0, result_r[bus_addr[`ASQ_RES_IDX_HI:`ASQ_RES_IDX_LO]]};
         end else begin
            case (bus_addr)
               `ASQ_ADDR_CTRL0: rdata_nxt = {29'h0, repeat_r, trgsel_r, start_r};
               `ASQ_ADDR_CTRL1: rdata_nxt = {28'h0, refcon_r, res10_r, width_r};
               `ASQ_ADDR_CTRL2: rdata_nxt = {30'h0, group_r};
               `ASQ_ADDR_STATUS: rdata_nxt = {31'h0, status_r};
               `ASQ_ADDR_ENABLE: rdata_nxt = {31'h0, enable_r};
               default: rdata_nxt = `ASQ_RST_RDATA;
            endcase
         end
      end
   end

   // read data register: valid only in the cycle after the strobe
   always @(posedge clk) begin
      if (rst) begin
         bus_rdata <= `ASQ_RST_RDATA;
      end else begin
         bus_rdata <= rdata_nxt;
      end
   end

endmodule // asq_sequencer

// File: pkg/asq_regs.vh
// register map, field positions, reset values and codes of the sweep sequencer
`ifndef ASQ_REGS_VH
`define ASQ_REGS_VH

// word-aligned byte addresses
`define ASQ_ADDR_CTRL0    8'h00
`define ASQ_ADDR_CTRL1    8'h04
`define ASQ_ADDR_CTRL2    8'h08
`define ASQ_ADDR_STATUS   8'h0c
`define ASQ_ADDR_CLEAR    8'h10
`define ASQ_ADDR_ENABLE   8'h14
`define ASQ_ADDR_RES_BASE 8'h20
`define ASQ_ADDR_RES_MASK 8'he3

// converter_control_0 fields
`define ASQ_C0_START   0
`define ASQ_C0_TRGSEL  1
`define ASQ_C0_REPEAT  2
// converter_control_1 fields
`define ASQ_C1_WIDTH_LO 0
`define ASQ_C1_WIDTH_HI 1
`define ASQ_C1_RES10    2
`define ASQ_C1_REFCON   3
// converter_control_2 fields
`define ASQ_C2_GROUP_LO 0
`define ASQ_C2_GROUP_HI 1
// interrupt status bits
`define ASQ_ST_DONE 0

// reset values, 8-bit result mask, channel step and channel count
`define ASQ_RST_WIDTH  2'h0
`define ASQ_RST_GROUP  2'h0
`define ASQ_RST_CHAN   3'h0
`define ASQ_RST_RESULT 10'h000
`define ASQ_RST_RDATA  32'h00000000
`define ASQ_MASK_8BIT  10'h0ff
`define ASQ_CHAN_ONE   3'h1
`define ASQ_NUM_CHAN   8
// channel index bits inside a result address
`define ASQ_RES_IDX_LO 2
`define ASQ_RES_IDX_HI 4

// sequencer states
`define ASQ_ST_IDLE 2'h0
`define ASQ_ST_ARM  2'h1
`define ASQ_ST_CONV 2'h2

`endif

// File: tb/asq_core_model.sv
// converter core stand-in answering each request after a set latency
`timescale 1ns/1ps
module asq_core_model (
   input wire clk,
   input wire rst,
   input wire conv_go,
   input wire [2:0] conv_channel,
   input wire [1:0] input_group_field,
   input wire [3:0] lat,
   output reg conv_done,
   output reg [9:0] conv_data
);
   reg run_r;
   reg [3:0] cnt_r;
   // data toggles outside done so a stale sample never matches
   always @(posedge clk) begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (rst) begin
         run_r <= 1'b0;
         conv_data <= 10'h155;
      end else if (conv_go) begin
         run_r <= 1'b1;
         cnt_r <= lat;
      end else if (run_r && cnt_r == 4'h0) begin
         run_r <= 1'b0;
         conv_done <= 1'b1;
         conv_data <= {input_group_field, conv_channel, 5'h1b};
      end else if (run_r) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule // asq_core_model

// File: tb/asq_seq_asserts.sv
// port checker of the sweep sequencer
`timescale 1ns/1ps
`include "asq_regs.vh"
module asq_seq_asserts (
   input wire clk,
   input wire rst,
   input wire [7:0] bus_addr,
   input wire [31:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   input wire [31:0] bus_rdata,
   input wire external_trigger_pin,
   input wire conv_go,
   input wire [2:0] conv_channel,
   input wire reference_connect_bit,
   input wire conv_done,
   input wire busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // control word 0 write seen at the port
   wire c0_wr = bus_wr && bus_addr == `ASQ_ADDR_CTRL0;
   a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
      else $error("read data outside read cycle");
   a_go_pulse: assert property (conv_go |=> !conv_go)
      else $error("request longer than one cycle");
   a_chan_step: assert property (conv_go && $past(conv_done) && conv_channel != 3'h0 |-> conv_channel == $past(conv_channel) + 3'h1)
      else $error("channel not ascending");
   a_go_cause: assert property (conv_go |-> $past(conv_done) || $past(bus_wr) || $past(external_trigger_pin, 2) && !$past(external_trigger_pin))
      else $error("request without cause");
   a_sw_start: assert property (c0_wr && bus_wdata[0] && !bus_wdata[1] && reference_connect_bit && !busy |=> conv_go && conv_channel == 3'h0)
      else $error("software start missed");
   a_ref_refuse: assert property (c0_wr && !reference_connect_bit && !busy |=> !busy)
      else $error("start taken without reference");
   a_ref_keep: assert property (busy && reference_connect_bit |=> reference_connect_bit)
      else $error("reference dropped while busy");
   a_halt_now: assert property (c0_wr && !bus_wdata[0] |=> !busy && !conv_go)
      else $error("halt not taken");
   cover property (conv_go && conv_channel == 3'h7);
   cover property ($fell(external_trigger_pin) && busy);
   cover property (c0_wr && !reference_connect_bit);
endmodule // asq_seq_asserts

bind asq_sequencer asq_seq_asserts u_chk (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .external_trigger_pin(external_trigger_pin),
   .conv_go(conv_go), .conv_channel(conv_channel), .reference_connect_bit(reference_connect_bit),
   .conv_done(conv_done), .busy(busy));

// File: tb/tb_adc_sweep_mode_sequencer.sv
// self-checking bench of the sweep sequencer
`timescale 1ns/1ps
`include "asq_regs.vh"
module tb_adc_sweep_mode_sequencer;
   reg clk = 1'b0, rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, ext = 1'b1;
   reg [7:0] bus_addr = 8'h00;
   reg [31:0] bus_wdata = 32'h0;
   reg [3:0] lat = 4'h0;
   wire [31:0] bus_rdata;
   wire conv_go, conv_res10, refcon, conv_done, busy, irq;
   wire [2:0] conv_channel;
   wire [1:0] grp;
   wire [9:0] conv_data;
   integer seed = 18, err_total = 0, n_tests = 0, n_go = 0, cyc = 0;
   integer w, g, i, r, b;
   asq_sequencer dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .external_trigger_pin(ext), .conv_go(conv_go),
      .conv_channel(conv_channel), .input_group_field(grp), .conv_res10(conv_res10),
      .reference_connect_bit(refcon), .conv_done(conv_done), .conv_data(conv_data), .busy(busy), .irq(irq));
   asq_core_model core (.clk(clk), .rst(rst), .conv_go(conv_go), .conv_channel(conv_channel),
      .input_group_field(grp), .lat(lat), .conv_done(conv_done), .conv_data(conv_data));
   initial forever #2.5 clk = ~clk;
   // count requests; the cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (conv_go === 1'b1) n_go <= n_go + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         end_of_test;
      end
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // write strobe for one cycle, then settle past the taking edge
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         bus_addr <= a;
         bus_wdata <= d;
         bus_wr <= 1'b1;
         @(posedge clk);
         bus_wr <= 1'b0;
         #1;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         @(posedge clk);
         bus_addr <= a;
         bus_rd <= 1'b1;
         @(posedge clk);
         bus_rd <= 1'b0;
         #1;
         chk(bus_rdata, e);
      end
   endtask
   task end_of_test;
      begin
         $display("mismatches %0d, checks %0d", err_total, n_tests);
         if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // group lands in bits 9:8 and is lost in 8-bit mode
   function [31:0] exp_res(input integer gg, input integer ii, input integer rr);
      exp_res = rr ? {22'h0, gg[1:0], ii[2:0], 5'h1b} : {24'h0, ii[2:0], 5'h1b};
   endfunction
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(8'h40, 32'h0);
      wr(`ASQ_ADDR_CTRL0, 32'h1);
      rd(`ASQ_ADDR_CTRL0, 32'h0);
      wr(`ASQ_ADDR_ENABLE, 32'h1);
      // connect the reference once and let it settle before any start
      wr(`ASQ_ADDR_CTRL1, 32'h8);
      repeat (200) @(posedge clk);
      // every width and groups 0 to 2, random resolution and latency
      for (w = 0; w < 4; w = w + 1)
         for (g = 0; g < 3; g = g + 1) begin
            r = $random(seed) & 1;
            lat <= $random(seed) & 7;
            wr(`ASQ_ADDR_CTRL1, 8 + 4 * r + w);
            wr(`ASQ_ADDR_CTRL2, g);
            chk(conv_res10, r);
            rd(`ASQ_ADDR_CTRL2, g);
            b = n_go;
            wr(`ASQ_ADDR_CTRL0, 32'h1);
            while (busy !== 1'b0) begin
               @(posedge clk);
               #1;
            end
            chk(n_go - b, 2 * w + 2);
            chk(irq, 1'b1);
            rd(`ASQ_ADDR_CTRL0, 32'h0);
            for (i = 0; i < 2 * w + 2; i = i + 1)
               rd(`ASQ_ADDR_RES_BASE + 4 * i, exp_res(g, i, r));
            wr(`ASQ_ADDR_CLEAR, 32'h1);
            chk(irq, 1'b0);
         end
      // repeat sweep wraps past the block end and raises nothing
      lat <= 4'h0;
      b = n_go;
      wr(`ASQ_ADDR_CTRL0, 32'h5);
      repeat (40) @(posedge clk);
      chk(n_go - b > 8, 1'b1);
      chk(irq, 1'b0);
      wr(`ASQ_ADDR_CTRL1, 4 * r + 3);
      rd(`ASQ_ADDR_CTRL1, 11 + 4 * r);
      wr(`ASQ_ADDR_CTRL0, 32'h0);
      chk(busy, 1'b0);
      // external trigger waits for the falling pin
      b = n_go;
      wr(`ASQ_ADDR_CTRL0, 32'h3);
      repeat (10) @(posedge clk);
      chk(n_go - b, 0);
      ext <= 1'b0;
      repeat (60) @(posedge clk);
      #1;
      chk(n_go - b, 8);
      chk(irq, 1'b1);
      rd(`ASQ_ADDR_CTRL0, 32'h3);
      end_of_test;
   end
endmodule // tb_adc_sweep_mode_sequencer
